// ==== icsc_map.vh ====
/*
  Constants for the input clock switch controller: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by the controller, its checker and its bench.
*/
`ifndef ICSC_MAP_VH
`define ICSC_MAP_VH

`define ICSC_AW              16
`define ICSC_DW              8

`define ICSC_A_ZDM           16'h0487
`define ICSC_A_BW0           16'h0508
`define ICSC_BW_N            6
`define ICSC_A_FA_ENTRY      16'h052B
`define ICSC_A_SWCTL         16'h0536
`define ICSC_A_MODE          16'h053A
`define ICSC_A_RAMP          16'h05A6
`define ICSC_A_STATUS        16'h05F0
`define ICSC_A_INCFG         16'h0949

`define ICSC_B_ZDM           0
`define ICSC_B_FA_ENTRY      0
`define ICSC_B_ABSORB        2
`define ICSC_F_POLICY_LO     0
`define ICSC_F_POLICY_HI     1
`define ICSC_POLICY_RSVD     2'h3
`define ICSC_B_RAMP          3

`define ICSC_RST_BUF_EN      4'hF
`define ICSC_RST_RX_TYPE     4'h0
`define ICSC_RST_BW          8'h00

`define ICSC_CLK_MHZ         25
`define ICSC_HOLD_NS         400
`define ICSC_HOLD_CYC        ((`ICSC_HOLD_NS * `ICSC_CLK_MHZ) / 1000)
`define ICSC_RAMP_US         10
`define ICSC_RAMP_CYC        (`ICSC_RAMP_US * `ICSC_CLK_MHZ)

`endif

// ==== icsc_ctrl.v ====
/*
  Input clock switch controller: input buffer and receiver controls,
  switch sequencing (phase absorb, ramped switch through short holdover,
  fast acquisition on loss of lock), loop bandwidth registers.
  Assumes a plain register port on i_clock, input selection and lock
  indication arriving asynchronously from pins or other clocks.
*/
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "icsc_map.vh"

module icsc_ctrl
(
  input  wire                   i_clock,
  input  wire                   i_rst,
  input  wire                   i_ce,
  input  wire [`ICSC_AW-1:0]    i_addr,
  input  wire [`ICSC_DW-1:0]    i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [`ICSC_DW-1:0]    o_rdata,
  input  wire [1:0]             i_sel_req,
  input  wire                   i_loss_of_lock,
  input  wire                   i_loss_of_signal,
  input  wire                   i_out_of_frequency,
  output reg  [3:0]             o_buf_en,
  output reg  [3:0]             o_rx_pulsed,
  output reg  [1:0]             o_sel_active,
  output reg                    o_holdover,
  output reg                    o_ramp_active,
  output reg                    o_phase_absorb,
  output reg                    o_fast_acq,
  output reg                    o_zero_delay_mode,
  output reg  [1:0]             o_switch_mode,
  output reg  [1:0]             o_switch_policy,
  output reg  [6*`ICSC_DW-1:0]  o_loop_bw,
  output reg                    o_loss_of_lock,
  output reg                    o_loss_of_signal,
  output reg                    o_out_of_frequency
);

  localparam ST_IDLE = 2'h0;
  localparam ST_HOLD = 2'h1;
  localparam ST_RAMP = 2'h2;
  localparam ST_STEP = 2'h3;

  // Counts fit in eight bits; cut on purpose
  localparam integer HOLD_INT = `ICSC_HOLD_CYC;
  localparam integer RAMP_INT = `ICSC_RAMP_CYC;
  localparam [7:0]   HOLD_CYC = HOLD_INT[7:0];
  localparam [7:0]   RAMP_CYC = RAMP_INT[7:0];

  // Bandwidth byte offsets, sized to the address
  localparam [15:0]  A_BW1    = `ICSC_A_BW0 + 16'h0001;
  localparam [15:0]  A_BW2    = `ICSC_A_BW0 + 16'h0002;
  localparam [15:0]  A_BW3    = `ICSC_A_BW0 + 16'h0003;
  localparam [15:0]  A_BW4    = `ICSC_A_BW0 + 16'h0004;
  localparam [15:0]  A_BW5    = `ICSC_A_BW0 + 16'h0005;

  reg  [3:0]          buf_en_r;
  reg  [3:0]          rx_type_r;
  reg                 absorb_en_r;
  reg  [1:0]          policy_r;
  reg  [1:0]          mode_r;
  reg                 ramp_en_r;
  reg                 fa_entry_r;
  reg                 zdm_r;
  reg  [`ICSC_DW-1:0] bw_r [0:`ICSC_BW_N-1];

  reg  [1:0]          sel_m_r;
  reg  [1:0]          sel_s_r;
  reg  [1:0]          sel_q_r;
  reg  [2:0]          flt_m_r;
  reg  [2:0]          flt_s_r;

  reg  [1:0]          state_r;
  reg  [1:0]          state_nxt;
  reg  [7:0]          cnt_r;
  reg  [7:0]          cnt_nxt;
  reg  [1:0]          sel_r;
  reg  [1:0]          sel_nxt;
  reg                 fa_r;
  reg                 fa_nxt;
  reg  [`ICSC_DW-1:0] rdata_nxt;

  wire                lol_s;
  wire                sel_steady;
  wire                sel_change;

  assign lol_s      = flt_s_r[0];
  // Code bits may land a cycle apart; act only on a settled code
  assign sel_steady = (sel_s_r == sel_q_r);
  // Only a change the block sees can be sequenced
  assign sel_change = sel_steady && (sel_s_r != sel_r);

  // Pins are asynchronous: two stages before any use
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sel_m_r <= 2'h0;
      sel_s_r <= 2'h0;
      sel_q_r <= 2'h0;
      flt_m_r <= 3'h0;
      flt_s_r <= 3'h0;
    end
    else if (i_ce)
    begin
      sel_m_r <= i_sel_req;
      sel_s_r <= sel_m_r;
      // Third stage only feeds the settle compare
      sel_q_r <= sel_s_r;
      flt_m_r <= {i_out_of_frequency, i_loss_of_signal, i_loss_of_lock};
      flt_s_r <= flt_m_r;
    end
  end

  // Control registers
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      buf_en_r    <= `ICSC_RST_BUF_EN;
      rx_type_r   <= `ICSC_RST_RX_TYPE;
      absorb_en_r <= 1'b0;
      policy_r    <= 2'h0;
      mode_r      <= 2'h0;
      ramp_en_r   <= 1'b0;
      fa_entry_r  <= 1'b0;
      zdm_r       <= 1'b0;
    end
    else if (i_ce && i_wr)
    begin
      case (i_addr)
        `ICSC_A_INCFG:
        begin
          buf_en_r  <= i_wdata[3:0];
          rx_type_r <= i_wdata[7:4];
        end
        `ICSC_A_SWCTL:
        begin
          absorb_en_r <= i_wdata[`ICSC_B_ABSORB];
          // Reserved policy code is refused, old policy kept
          if (i_wdata[1:0] != `ICSC_POLICY_RSVD)
          begin
            policy_r <= i_wdata[1:0];
          end
        end
        `ICSC_A_MODE:
        begin
          mode_r <= i_wdata[1:0];
        end
        `ICSC_A_RAMP:
        begin
          ramp_en_r <= i_wdata[`ICSC_B_RAMP];
        end
        `ICSC_A_FA_ENTRY:
        begin
          fa_entry_r <= i_wdata[`ICSC_B_FA_ENTRY];
        end
        `ICSC_A_ZDM:
        begin
          zdm_r <= i_wdata[`ICSC_B_ZDM];
        end
        default:
        begin
          zdm_r <= zdm_r;
        end
      endcase
    end
  end

  // Bandwidth block, one byte per entry
  genvar gi;
  generate
    for (gi = 0; gi < `ICSC_BW_N; gi = gi + 1)
    begin : g_bw
      // Each byte decodes its own offset
      localparam integer BW_OFF  = `ICSC_A_BW0 + gi;
      localparam [15:0]  BW_ADDR = BW_OFF[15:0];
      always @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
        begin
          bw_r[gi] <= `ICSC_RST_BW;
        end
        else if (i_ce && i_wr && (i_addr == BW_ADDR))
        begin
          bw_r[gi] <= i_wdata;
        end
      end
    end
  endgenerate

  // Switch sequencer
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    sel_nxt   = sel_r;
    fa_nxt    = fa_r;
    case (state_r)
      ST_IDLE:
      begin
        fa_nxt = 1'b0;
        if (sel_change)
        begin
          if (ramp_en_r)
          begin
            state_nxt = ST_HOLD;
            cnt_nxt   = HOLD_CYC;
          end
          else
          begin
            // Frequency steps; loop pulls in at its bandwidth
            state_nxt = ST_STEP;
            cnt_nxt   = RAMP_CYC;
            sel_nxt   = sel_s_r;
          end
        end
      end
      ST_HOLD:
      begin
        // Output runs from holdover, so the input swap cannot cut a pulse
        if (cnt_r != 8'h01)
        begin
          cnt_nxt = cnt_r - 8'h01;
        end
        // A code still settling keeps the hold one more cycle
        else if (sel_steady)
        begin
          sel_nxt   = sel_s_r;
          state_nxt = ST_RAMP;
          cnt_nxt   = RAMP_CYC;
        end
      end
      ST_RAMP, ST_STEP:
      begin
        // Same ramp length as a holdover exit
        if (cnt_r == 8'h01)
        begin
          state_nxt = ST_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (state_nxt != ST_IDLE && fa_entry_r && lol_s)
    begin
      fa_nxt = 1'b1;
    end
    else if (!lol_s)
    begin
      fa_nxt = 1'b0;
    end
  end

  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      sel_r   <= 2'h0;
      fa_r    <= 1'b0;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sel_r   <= sel_nxt;
      fa_r    <= fa_nxt;
    end
  end

  // Read mux; unmapped offsets read zero
  always @*
  begin
    rdata_nxt = 8'h00;
    if (i_rd)
    begin
      case (i_addr)
        `ICSC_A_INCFG:    rdata_nxt = {rx_type_r, buf_en_r};
        `ICSC_A_SWCTL:    rdata_nxt = {5'h00, absorb_en_r, policy_r};
        `ICSC_A_MODE:     rdata_nxt = {6'h00, mode_r};
        `ICSC_A_RAMP:     rdata_nxt = {4'h0, ramp_en_r, 3'h0};
        `ICSC_A_FA_ENTRY: rdata_nxt = {7'h00, fa_entry_r};
        `ICSC_A_ZDM:      rdata_nxt = {7'h00, zdm_r};
        `ICSC_A_STATUS:   rdata_nxt = {1'b0, fa_r, state_r, 2'h0, sel_r};
        `ICSC_A_BW0:      rdata_nxt = bw_r[0];
        A_BW1:            rdata_nxt = bw_r[1];
        A_BW2:            rdata_nxt = bw_r[2];
        A_BW3:            rdata_nxt = bw_r[3];
        A_BW4:            rdata_nxt = bw_r[4];
        A_BW5:            rdata_nxt = bw_r[5];
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  // Outputs all from flops
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata            <= 8'h00;
      o_buf_en           <= `ICSC_RST_BUF_EN;
      o_rx_pulsed        <= `ICSC_RST_RX_TYPE;
      o_sel_active       <= 2'h0;
      o_holdover         <= 1'b0;
      o_ramp_active      <= 1'b0;
      o_phase_absorb     <= 1'b0;
      o_fast_acq         <= 1'b0;
      o_zero_delay_mode  <= 1'b0;
      o_switch_mode      <= 2'h0;
      o_switch_policy    <= 2'h0;
      o_loop_bw          <= {(6*`ICSC_DW){1'b0}};
      o_loss_of_lock     <= 1'b0;
      o_loss_of_signal   <= 1'b0;
      o_out_of_frequency <= 1'b0;
    end
    else if (i_ce)
    begin
      o_rdata            <= rdata_nxt;
      o_buf_en           <= buf_en_r;
      o_rx_pulsed        <= rx_type_r;
      o_sel_active       <= sel_nxt;
      o_holdover         <= (state_nxt == ST_HOLD);
      o_ramp_active      <= (state_nxt == ST_RAMP);
      // Absorb only inside a seen switch; off gives gradual phase walk
      // Loop bandwidth paces that walk; nothing here shapes it
      o_phase_absorb     <= absorb_en_r & ~zdm_r & (state_nxt != ST_IDLE);
      o_fast_acq         <= fa_nxt;
      o_zero_delay_mode  <= zdm_r;
      o_switch_mode      <= mode_r;
      o_switch_policy    <= policy_r;
      o_loop_bw          <= {bw_r[5], bw_r[4], bw_r[3],
                             bw_r[2], bw_r[1], bw_r[0]};
      // Monitors are set for gaps upstream; faults pass through as given
      o_loss_of_lock     <= lol_s;
      o_loss_of_signal   <= flt_s_r[1];
      o_out_of_frequency <= flt_s_r[2];
    end
  end

endmodule

// ==== icsc_chk_assertions.sv ====
/*
  Port checker for icsc_ctrl: register port, switch sequence, faults.
  Assumes binding to icsc_ctrl with its clock and async reset.
*/
`timescale 1ns/10ps
`include "icsc_map.vh"
module icsc_chk
(
  input wire [`ICSC_AW-1:0] i_addr,
  input wire [7:0]          i_wdata,
  input wire [7:0]          o_rdata,
  input wire [3:0]          o_buf_en,
  input wire [1:0]          o_sel_active,
  input wire                i_clock,
  input wire                i_rst,
  input wire                i_ce,
  input wire                i_wr,
  input wire                i_rd,
  input wire                i_loss_of_signal,
  input wire                o_loss_of_signal,
  input wire                o_holdover,
  input wire                o_ramp_active,
  input wire                o_phase_absorb,
  input wire                o_zero_delay_mode
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  buf_write_a: assert property (
    i_ce && i_wr && i_addr == 16'h0949 |-> ##2 o_buf_en == $past(i_wdata[3:0], 2))
    else $error("buffer enable write lost");
  absorb_zdm_a: assert property (o_phase_absorb |-> !o_zero_delay_mode)
    else $error("absorb in zero delay mode");
  hold_len_a: assert property (
    $rose(o_holdover) |-> o_holdover[*8] ##1 o_holdover ##1 o_holdover ##1 !o_holdover)
    else $error("holdover length wrong");
  hold_exit_a: assert property (
    $fell(o_holdover) |-> o_ramp_active && $changed(o_sel_active))
    else $error("holdover exit wrong");
  ramp_len_a: assert property (
    $rose(o_ramp_active) |-> (o_ramp_active throughout ##249 1'b1) ##1 !o_ramp_active)
    else $error("ramp length wrong");
  hold_ramp_excl_a: assert property (!(o_holdover && o_ramp_active))
    else $error("holdover and ramp together");
  fault_pass_a: assert property (o_loss_of_signal == $past(i_loss_of_signal, 3))
    else $error("signal fault not passed");
endmodule
bind icsc_ctrl icsc_chk u_chk
(
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_buf_en(o_buf_en),
  .o_sel_active(o_sel_active), .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
  .i_wr(i_wr), .i_rd(i_rd), .i_loss_of_signal(i_loss_of_signal),
  .o_loss_of_signal(o_loss_of_signal), .o_holdover(o_holdover),
  .o_ramp_active(o_ramp_active), .o_phase_absorb(o_phase_absorb),
  .o_zero_delay_mode(o_zero_delay_mode)
);

// ==== icsc_src_model.sv ====
/*
  Model of the reference sources and their monitors.
  Assumes the bench commands selection and faults after clock edges.
*/
`timescale 1ns/10ps
module icsc_src_model
(
  input  wire       i_clock,
  input  wire [1:0] i_pick,
  input  wire       i_lose,
  input  wire [1:0] i_fault,
  output reg  [1:0] o_sel_req,
  output reg        o_lol,
  output reg        o_los,
  output reg        o_oof
);
  // Sources assumed in range and gapped within limits, so no fault unasked
  always @(posedge i_clock)
  begin
    o_sel_req <= i_pick;
    o_lol     <= i_lose;
    {o_los, o_oof} <= i_fault;
  end
endmodule

// ==== icsc_ctrl_tb.sv ====
/*
  Self-checking bench for icsc_ctrl with a source model.
  Assumes the register map header and the bound checker.
*/
`timescale 1ns/10ps
`include "icsc_map.vh"
module icsc_ctrl_tb;
  logic        i_clock = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, lose = 1'b0, ab;
  logic        ce = 1'b1;
  logic [15:0] i_addr = 16'h0000, lf = 16'h0003;
  logic [7:0]  i_wdata = 8'h00, rd_v, d;
  logic [1:0]  pick = 2'h0, flt = 2'h0, pol;
  wire  [1:0]  sel_req, o_sel_active, o_switch_mode, o_switch_policy;
  wire  [7:0]  o_rdata;
  wire  [3:0]  o_buf_en, o_rx_pulsed;
  wire  [47:0] o_loop_bw;
  wire         loss_of_lock, loss_of_signal, out_of_frequency, o_holdover, o_ramp_active, o_phase_absorb, o_fast_acq;
  wire         o_zero_delay_mode, o_lol, o_los, o_oof;
  int          err_total = 0, check_count = 0, n, k, nh, nr;
  always #20 i_clock = ~i_clock;
  icsc_src_model src (.i_clock(i_clock), .i_pick(pick), .i_lose(lose), .i_fault(flt),
    .o_sel_req(sel_req), .o_lol(loss_of_lock), .o_los(loss_of_signal), .o_oof(out_of_frequency));
  icsc_ctrl dut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sel_req(sel_req),
    .i_loss_of_lock(loss_of_lock), .i_loss_of_signal(loss_of_signal), .i_out_of_frequency(out_of_frequency),
    .o_buf_en(o_buf_en), .o_rx_pulsed(o_rx_pulsed), .o_sel_active(o_sel_active),
    .o_holdover(o_holdover), .o_ramp_active(o_ramp_active), .o_phase_absorb(o_phase_absorb),
    .o_fast_acq(o_fast_acq), .o_zero_delay_mode(o_zero_delay_mode),
    .o_switch_mode(o_switch_mode), .o_switch_policy(o_switch_policy), .o_loop_bw(o_loop_bw),
    .o_loss_of_lock(o_lol), .o_loss_of_signal(o_los), .o_out_of_frequency(o_oof));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Reserved policy code keeps the old one
  function automatic logic [1:0] exp_pol(input logic [1:0] old, input logic [1:0] w);
    return (w == 2'h3) ? old : w;
  endfunction
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_port(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask
  // Returns once idle for ramped switches; a step switch still runs on
  task automatic sw(input logic [1:0] p);
    nh = 0;
    nr = 0;
    @(posedge i_clock);
    pick <= p;
    for (n = 0; n < 12 && o_holdover !== 1'b1 && o_sel_active !== p; n++) cyc(1);
    ab = o_phase_absorb;
    while (o_holdover === 1'b1 && nh < 400) begin nh++; cyc(1); end
    while (o_ramp_active === 1'b1 && nr < 400) begin nr++; cyc(1); end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    print_verdict;
  end
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    cyc(1);
    chk_port(o_buf_en, 4'hF);
    rd(16'h0949);
    chk_reg(rd_v, 8'h0F);
    for (k = 0; k < 5; k++)
    begin
      lf = lfsr(lf);
      d = (k == 4) ? 8'hF0 : lf[7:0];
      wr(16'h0949, d);
      rd(16'h0949);
      chk_reg(rd_v, d);
      chk_port({o_rx_pulsed, o_buf_en}, d);
    end
    // Enable low: a write must not land
    @(posedge i_clock);
    ce <= 1'b0;
    wr(16'h0949, 8'h5A);
    ce <= 1'b1;
    rd(16'h0949);
    chk_reg(rd_v, 8'hF0);
    chk_port({o_rx_pulsed, o_buf_en}, 8'hF0);
    pol = 2'h0;
    for (k = 0; k < 4; k++)
    begin
      wr(16'h0536, {6'h01, k[1:0]});
      pol = exp_pol(pol, k[1:0]);
      wr(16'h053A, {6'h00, k[1:0]});
      cyc(2);
      chk_port(o_switch_policy, pol);
      chk_port(o_switch_mode, k[1:0]);
    end
    rd(16'h0536);
    chk_reg(rd_v, {5'h00, 1'b1, pol});
    rd(16'h053A);
    chk_reg(rd_v, 8'h03);
    for (k = 0; k < 6; k++)
    begin
      lf = lfsr(lf);
      wr(16'h0508 + k[15:0], lf[7:0]);
      cyc(2);
      chk_port(o_loop_bw[8*k+:8], lf[7:0]);
      rd(16'h0508 + k[15:0]);
      chk_reg(rd_v, lf[7:0]);
    end
    rd(16'h0100);
    chk_reg(rd_v, 8'h00);
    // Near-frequency inputs: ramp with absorb on
    wr(16'h05A6, 8'h08);
    cyc(2);
    sw(2'h1);
    chk_port(48'(nh), 48'(`ICSC_HOLD_CYC));
    chk_port(48'(nr), 48'(`ICSC_RAMP_CYC));
    chk_port({ab, o_sel_active}, 3'h5);
    wr(16'h05A6, 8'h00);
    wr(16'h0487, 8'h01);
    cyc(2);
    sw(2'h2);
    chk_port({nh, ab, o_sel_active}, 35'h2);
    chk_port(o_zero_delay_mode, 1'b1);
    // Step sequence running toward input 2
    rd(16'h05F0);
    chk_reg(rd_v, 8'h32);
    cyc(260);
    wr(16'h0487, 8'h00);
    wr(16'h052B, 8'h01);
    sw(2'h3);
    @(posedge i_clock);
    lose <= 1'b1;
    cyc(8);
    chk_port(o_fast_acq, 1'b1);
    @(posedge i_clock);
    lose <= 1'b0;
    cyc(8);
    chk_port(o_fast_acq, 1'b0);
    cyc(260);
    wr(16'h052B, 8'h00);
    sw(2'h0);
    @(posedge i_clock);
    lose <= 1'b1;
    cyc(8);
    chk_port({o_fast_acq, o_lol}, 2'h1);
    @(posedge i_clock);
    lose <= 1'b0;
    cyc(260);
    for (k = 0; k < 8; k++)
    begin
      lf = lfsr(lf);
      @(posedge i_clock);
      flt <= lf[1:0];
      cyc(5);
      chk_port({o_los, o_oof}, lf[1:0]);
    end
    print_verdict;
  end
endmodule
